// *** scc_pkg.sv ***
// Shared constants for the servo command select and clear block
package scc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PRESET1 = 8'h04;
    localparam logic [7:0] ADDR_PRESET2 = 8'h08;
    localparam logic [7:0] ADDR_PRESET3 = 8'h0C;
    localparam logic [7:0] ADDR_FF_FIX  = 8'h10;
    localparam logic [7:0] ADDR_GAIN    = 8'h14;
    localparam logic [7:0] ADDR_ASSIGN0 = 8'h18;
    localparam logic [7:0] ADDR_ASSIGN1 = 8'h1C;
    localparam logic [7:0] ADDR_DEV     = 8'h20;
    localparam logic [7:0] ADDR_STATUS  = 8'h24;
    localparam logic [7:0] ADDR_SPEED   = 8'h28;
    localparam logic [7:0] ADDR_FF_OUT  = 8'h2C;

    // Control register field positions
    localparam int STOP_LSB  = 0;
    localparam int CLR_LSB   = 4;
    localparam int FFSRC_LSB = 8;

    // Function assignment byte: input index, inverted sense, enable
    localparam int ASG_IDX_LSB = 0;
    localparam int ASG_INV_BIT = 3;
    localparam int ASG_EN_BIT  = 4;
    localparam int FN_COUNT    = 7;
    localparam int FN_SEL_A    = 0;
    localparam int FN_SEL_B    = 1;
    localparam int FN_RUN      = 2;
    localparam int FN_DIR      = 3;
    localparam int FN_RUN_FWD  = 4;
    localparam int FN_RUN_REV  = 5;
    localparam int FN_FF_EN    = 6;

    // Setting limits
    localparam logic [11:0] GAIN_MAX      = 12'hFA0;
    localparam logic [15:0] FF_FIX_MAX    = 16'h270F;
    localparam logic [15:0] FF_FIX_MIN    = 16'hD8F1;
    localparam logic [28:0] MV_PER_VOLT   = 29'h0000_03E8;

    // Reset values
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [14:0] PRESET_RESET  = 15'h0000;
    localparam logic [15:0] FF_FIX_RESET  = 16'h0000;
    localparam logic [11:0] GAIN_RESET    = 12'h1F4;
    localparam logic [55:0] ASSIGN_RESET  = 56'h00_0000_0000_0000;

    // Positioning stop location
    typedef enum logic [1:0]
    {
        STOP_BETWEEN = 2'b00,
        STOP_EDGE    = 2'b01
    } scc_stop_type;

    // Deviation clear modes
    typedef enum logic [1:0]
    {
        CLR_OFF_LEVEL  = 2'b00,
        CLR_OFF_EDGE   = 2'b01,
        CLR_KEEP_LEVEL = 2'b10,
        CLR_KEEP_EDGE  = 2'b11
    } scc_clr_type;

    // Feed-forward source
    typedef enum logic [1:0]
    {
        FF_ANALOG = 2'b01,
        FF_FIXED  = 2'b10
    } scc_ffsrc_type;

endpackage

// *** scc_sync.sv ***
// Two-stage synchroniser for the general inputs and the clear input
`timescale 1ns/10ps
`default_nettype none
module scc_sync
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Asynchronous pins and their synchronised copies
    input  wire logic [8:0] pin_in,
    output logic      [8:0] pin_sync
);

    typedef struct packed
    {
        logic [8:0] stage1;
        logic [8:0] stage2;
    } scc_sync_state_type;

    scc_sync_state_type state_reg;
    scc_sync_state_type state_next;

    always_comb
    begin
        state_next.stage1 = pin_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign pin_sync = state_reg.stage2;

endmodule
`default_nettype wire

// *** scc_core.sv ***
// Servo command selection: stop location, deviation clear, presets, feed-forward
// Behaviour
// R01: Stop location 00 means between encoder pulses, 01 means on pulse edge.
// R02: A clear request from the host forces the deviation counter to zero.
// R03: Mode 0H: zero while servo off and while clear input is active.
// R04: Mode 1H: zero while servo off, and once per clear rising edge.
// R05: Mode 2H: keep count when servo off; clear while clear input active.
// R06: Mode 3H: keep count when servo off; clear on clear rising edge only.
// R07: Three preset speeds, each 0 to 32767 rpm.
// R08: Presets apply only when their select condition holds, else analog command.
// R09: Each function is tied to one of eight general inputs, ON or OFF.
// R10: Run valid with direction invalid turns forward; both valid turn reverse.
// R11: Positive-move valid drives forward, negative-move valid drives reverse.
// R12: Feed-forward added in position control only while its select holds.
// R13: Source 01 takes analog input, 02 takes the fixed preset value.
// R14: Fixed feed-forward value is signed, -9999 to +9999 rpm.
// R15: One gain, 0 to 4000 rpm per volt, scales analog command and compensation.
// R16: Analog compensation comes from the analog velocity command channel.
// R17: Feed-forward enable has its own input assignment, apart from source.
// R18: Select A alone preset one, B alone two, both three, none analog.
// R19: Positive and negative move both or neither valid gives zero speed.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module scc_core
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Host pins
    input  wire logic [7:0]         general_input,
    input  wire logic               deviation_zero_request,
    // Amplifier state and pulse streams, same clock
    input  wire logic               servo_on,
    input  wire logic               position_mode,
    input  wire logic               cmd_step_fwd,
    input  wire logic               cmd_step_rev,
    input  wire logic               fb_step_fwd,
    input  wire logic               fb_step_rev,
    input  wire logic signed [15:0] analog_cmd_mv,
    // Command outputs
    output logic signed [31:0]      deviation_count,
    output logic                    stop_on_pulse_edge,
    output logic signed [16:0]      speed_command_rpm,
    output logic signed [16:0]      feedforward_rpm
);

    typedef struct packed
    {
        logic [1:0]         stop_sel;
        logic [1:0]         clr_mode;
        logic [1:0]         ff_src;
        logic [2:0][14:0]   preset;
        logic signed [15:0] ff_fixed;
        logic [11:0]        gain;
        logic [55:0]        assign_cfg;
        logic               clr_prev;
        logic [31:0]        dev;
        logic signed [16:0] speed;
        logic signed [16:0] ff;
        logic               stop_edge;
        logic [31:0]        rdata;
    } scc_core_state_type;

    scc_core_state_type state_reg;
    scc_core_state_type state_next;

    logic [8:0]          pins_sync;
    logic [7:0]          gi_sync;
    logic                clr_sync;
    logic [6:0]          cond;
    logic                clr_rise;
    logic                hold_zero;
    logic                addr_ok;
    logic [31:0]         rd_mux;
    logic signed [28:0]  scaled_wide;
    logic signed [16:0]  analog_rpm;
    logic signed [16:0]  preset_mag;
    logic                preset_used;
    logic signed [15:0]  wr_ff;
    logic [11:0]         wr_gain;

    // Host pins are asynchronous to core_clk
    scc_sync u_sync
    (
        .core_clk (core_clk),
        .resetn   (resetn),
        .pin_in   ({deviation_zero_request, general_input}),
        .pin_sync (pins_sync)
    );

    assign gi_sync  = pins_sync[7:0];
    assign clr_sync = pins_sync[8];

    // Per-function condition on an assigned general input
    genvar fn;
    generate
        for (fn = 0; fn < scc_pkg::FN_COUNT; fn++)
        begin : g_cond
            logic [7:0] asg;
            assign asg = state_reg.assign_cfg[fn*8 +: 8];
            assign cond[fn] = asg[scc_pkg::ASG_EN_BIT] &&
                (gi_sync[asg[scc_pkg::ASG_IDX_LSB +: 3]] ^ asg[scc_pkg::ASG_INV_BIT]); // R09
        end
    endgenerate

    // Shared analog scaling; millivolts times rpm per volt
    assign scaled_wide = 29'(analog_cmd_mv) * $signed({17'h0_0000, state_reg.gain}); // R15 R16
    assign analog_rpm  = 17'(scaled_wide / $signed(scc_pkg::MV_PER_VOLT));           // R15

    always_comb
    begin
        case (paddr)
            scc_pkg::ADDR_CTRL,    scc_pkg::ADDR_PRESET1, scc_pkg::ADDR_PRESET2,
            scc_pkg::ADDR_PRESET3, scc_pkg::ADDR_FF_FIX,  scc_pkg::ADDR_GAIN,
            scc_pkg::ADDR_ASSIGN0, scc_pkg::ADDR_ASSIGN1, scc_pkg::ADDR_DEV,
            scc_pkg::ADDR_STATUS,  scc_pkg::ADDR_SPEED,   scc_pkg::ADDR_FF_OUT:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            scc_pkg::ADDR_CTRL:
            begin
                rd_mux[scc_pkg::STOP_LSB +: 2]  = state_reg.stop_sel;
                rd_mux[scc_pkg::CLR_LSB +: 2]   = state_reg.clr_mode;
                rd_mux[scc_pkg::FFSRC_LSB +: 2] = state_reg.ff_src;
            end
            scc_pkg::ADDR_PRESET1: rd_mux[14:0] = state_reg.preset[0];
            scc_pkg::ADDR_PRESET2: rd_mux[14:0] = state_reg.preset[1];
            scc_pkg::ADDR_PRESET3: rd_mux[14:0] = state_reg.preset[2];
            scc_pkg::ADDR_FF_FIX:  rd_mux = 32'(state_reg.ff_fixed);
            scc_pkg::ADDR_GAIN:    rd_mux[11:0] = state_reg.gain;
            scc_pkg::ADDR_ASSIGN0: rd_mux = state_reg.assign_cfg[31:0];
            scc_pkg::ADDR_ASSIGN1: rd_mux[23:0] = state_reg.assign_cfg[55:32];
            scc_pkg::ADDR_DEV:     rd_mux = state_reg.dev;
            scc_pkg::ADDR_STATUS:
            begin
                rd_mux[6:0]  = cond;
                rd_mux[8]    = clr_sync;
                rd_mux[9]    = hold_zero;
                rd_mux[10]   = preset_used;
                rd_mux[11]   = state_reg.stop_edge;
            end
            scc_pkg::ADDR_SPEED:   rd_mux = 32'(state_reg.speed);
            scc_pkg::ADDR_FF_OUT:  rd_mux = 32'(state_reg.ff);
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Write-side clamps keep settings inside their legal ranges
    always_comb
    begin
        wr_ff = $signed(pwdata[15:0]);
        if (wr_ff > $signed(scc_pkg::FF_FIX_MAX))
            wr_ff = $signed(scc_pkg::FF_FIX_MAX);                                       // R14
        else if (wr_ff < $signed(scc_pkg::FF_FIX_MIN))
            wr_ff = $signed(scc_pkg::FF_FIX_MIN);                                       // R14
        wr_gain = (pwdata[31:12] != 20'h0_0000 || pwdata[11:0] > scc_pkg::GAIN_MAX)
                  ? scc_pkg::GAIN_MAX : pwdata[11:0];                                   // R15
    end

    // Deviation clear decision
    always_comb
    begin
        clr_rise  = clr_sync && !state_reg.clr_prev;
        hold_zero = 1'b0;
        unique case (scc_pkg::scc_clr_type'(state_reg.clr_mode))
            scc_pkg::CLR_OFF_LEVEL:  hold_zero = !servo_on || clr_sync;  // R03
            scc_pkg::CLR_OFF_EDGE:   hold_zero = !servo_on || clr_rise;  // R04
            scc_pkg::CLR_KEEP_LEVEL: hold_zero = clr_sync;               // R05
            scc_pkg::CLR_KEEP_EDGE:  hold_zero = clr_rise;               // R06
        endcase
    end

    // Preset choice from the two select conditions
    always_comb
    begin
        preset_used = cond[scc_pkg::FN_SEL_A] || cond[scc_pkg::FN_SEL_B];        // R08
        preset_mag  = 17'sh0_0000;
        unique case ({cond[scc_pkg::FN_SEL_B], cond[scc_pkg::FN_SEL_A]})
            2'b01:   preset_mag = $signed({2'b00, state_reg.preset[0]});         // R18
            2'b10:   preset_mag = $signed({2'b00, state_reg.preset[1]});         // R18
            2'b11:   preset_mag = $signed({2'b00, state_reg.preset[2]});         // R18
            2'b00:   preset_mag = 17'sh0_0000;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;

        // APB read data is captured in the setup cycle
        if (psel && !penable)
            state_next.rdata = rd_mux;

        if (psel && penable && pwrite)
        begin
            case (paddr)
                scc_pkg::ADDR_CTRL:
                begin
                    state_next.stop_sel = pwdata[scc_pkg::STOP_LSB +: 2];
                    state_next.clr_mode = pwdata[scc_pkg::CLR_LSB +: 2];
                    state_next.ff_src   = pwdata[scc_pkg::FFSRC_LSB +: 2];
                end
                scc_pkg::ADDR_PRESET1: state_next.preset[0] = pwdata[14:0];  // R07
                scc_pkg::ADDR_PRESET2: state_next.preset[1] = pwdata[14:0];  // R07
                scc_pkg::ADDR_PRESET3: state_next.preset[2] = pwdata[14:0];  // R07
                scc_pkg::ADDR_FF_FIX:  state_next.ff_fixed  = wr_ff;
                scc_pkg::ADDR_GAIN:    state_next.gain      = wr_gain;
                scc_pkg::ADDR_ASSIGN0: state_next.assign_cfg[31:0]  = pwdata;
                scc_pkg::ADDR_ASSIGN1: state_next.assign_cfg[55:32] = pwdata[23:0];
                default:               state_next.rdata = state_reg.rdata;
            endcase
        end

        // Deviation count; the clear wins over pulses in the same cycle
        state_next.clr_prev = clr_sync;
        state_next.dev = state_reg.dev + 32'(cmd_step_fwd) - 32'(cmd_step_rev)
                         - 32'(fb_step_fwd) + 32'(fb_step_rev);
        if (hold_zero)
            state_next.dev = 32'h0000_0000;                                      // R02

        // Stop location handed to the position loop
        state_next.stop_edge =
            (scc_pkg::scc_stop_type'(state_reg.stop_sel) == scc_pkg::STOP_EDGE); // R01

        // Velocity command
        if (!preset_used)
            state_next.speed = analog_rpm;                                       // R08
        else if (cond[scc_pkg::FN_RUN])
            state_next.speed = cond[scc_pkg::FN_DIR] ? -preset_mag : preset_mag; // R10
        else if (cond[scc_pkg::FN_RUN_FWD] && !cond[scc_pkg::FN_RUN_REV])
            state_next.speed = preset_mag;                                       // R11
        else if (cond[scc_pkg::FN_RUN_REV] && !cond[scc_pkg::FN_RUN_FWD])
            state_next.speed = -preset_mag;                                      // R11
        else
            state_next.speed = 17'sh0_0000;                                      // R19

        // Feed-forward term, only in position control
        state_next.ff = 17'sh0_0000;
        if (position_mode && cond[scc_pkg::FN_FF_EN])                            // R12 R17
        begin
            if (state_reg.ff_src == scc_pkg::FF_ANALOG)
                state_next.ff = analog_rpm;                                      // R13 R16
            else if (state_reg.ff_src == scc_pkg::FF_FIXED)
                state_next.ff = 17'(state_reg.ff_fixed);                         // R13
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg.stop_sel   <= scc_pkg::CTRL_RESET[scc_pkg::STOP_LSB +: 2];
            state_reg.clr_mode   <= scc_pkg::CTRL_RESET[scc_pkg::CLR_LSB +: 2];
            state_reg.ff_src     <= scc_pkg::CTRL_RESET[scc_pkg::FFSRC_LSB +: 2];
            state_reg.preset     <= {3{scc_pkg::PRESET_RESET}};
            state_reg.ff_fixed   <= scc_pkg::FF_FIX_RESET;
            state_reg.gain       <= scc_pkg::GAIN_RESET;
            state_reg.assign_cfg <= scc_pkg::ASSIGN_RESET;
            state_reg.clr_prev   <= 1'b0;
            state_reg.dev        <= 32'h0000_0000;
            state_reg.speed      <= 17'sh0_0000;
            state_reg.ff         <= 17'sh0_0000;
            state_reg.stop_edge  <= 1'b0;
            state_reg.rdata      <= 32'h0000_0000;
        end
        else
            state_reg <= state_next;
    end

    // Zero-wait slave; unmapped offsets answer with an error
    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !addr_ok;
    assign prdata             = state_reg.rdata;
    assign deviation_count    = $signed(state_reg.dev);
    assign stop_on_pulse_edge = state_reg.stop_edge;
    assign speed_command_rpm  = state_reg.speed;
    assign feedforward_rpm    = state_reg.ff;

endmodule
`default_nettype wire

// *** scc_sva.sv ***
// Assertion checker for the servo command select and clear block
`timescale 1ns/10ps
`default_nettype none
module scc_sva
(
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               resetn,
    // APB writes, for the control shadow
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    // Amplifier and host inputs
    input wire logic               servo_on,
    input wire logic               position_mode,
    input wire logic               cmd_step_fwd,
    input wire logic               cmd_step_rev,
    input wire logic               fb_step_fwd,
    input wire logic               fb_step_rev,
    input wire logic               deviation_zero_request,
    // Outputs
    input wire logic signed [31:0] deviation_count,
    input wire logic               stop_on_pulse_edge,
    input wire logic signed [16:0] feedforward_rpm
);
    logic [9:0] ctrl_reg;
    logic       step_any;

    assign step_any = cmd_step_fwd | cmd_step_rev | fb_step_fwd | fb_step_rev;

    // Shadow taken at the same edge as the slave commits it
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_reg <= 10'h000;
        else if (psel && penable && pwrite && paddr == scc_pkg::ADDR_CTRL)
            ctrl_reg <= pwdata[9:0];
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_stop_edge: assert property (stop_on_pulse_edge == ($past(ctrl_reg[1:0]) == 2'b01))
        else $error("stop location output wrong");
    a_off_zero: assert property (!servo_on && !ctrl_reg[5] |=> deviation_count == 0)
        else $error("count not zero with servo off");
    // Pin passes two flops before the logic sees it
    a_level_clear: assert property
        (deviation_zero_request [*3] ##0 !ctrl_reg[4] |=> deviation_count == 0)
        else $error("level clear missed");
    a_edge_clear: assert property
        ($rose(deviation_zero_request) ##2 ctrl_reg[4] |=> deviation_count == 0)
        else $error("edge clear missed");
    a_keep_count: assert property
        ((!deviation_zero_request) [*4] ##0 (ctrl_reg[5] && !step_any)
            |=> $stable(deviation_count))
        else $error("count changed without cause");
    a_ff_mode: assert property (!position_mode |=> feedforward_rpm == 0)
        else $error("feed-forward outside position control");
    a_ff_src: assert property (ctrl_reg[9] == ctrl_reg[8] |=> feedforward_rpm == 0)
        else $error("feed-forward with no source");
    a_ff_range: assert property (ctrl_reg[9:8] == 2'b10 |=>
        feedforward_rpm >= -9999 && feedforward_rpm <= 9999)
        else $error("fixed feed-forward out of range");
endmodule

bind scc_core scc_sva u_sva
(
    .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .servo_on,
    .position_mode, .cmd_step_fwd, .cmd_step_rev, .fb_step_fwd, .fb_step_rev,
    .deviation_zero_request, .deviation_count, .stop_on_pulse_edge, .feedforward_rpm
);
`default_nettype wire

// *** scc_host.sv ***
// Host motion controller model driving the general and clear pins
`timescale 1ns/10ps
`default_nettype none
module scc_host
(
    // Clock
    input  wire logic       core_clk,
    // Wanted levels and host lag in cycles
    input  wire logic [7:0] gi_set,
    input  wire logic       clr_set,
    input  wire logic [3:0] lag,
    // Pins
    output logic      [7:0] general_input,
    output logic            deviation_zero_request
);
    logic [8:0] pipe [0:15] = '{default: 9'h000};

    // Slow host: levels reach the pins lag + 1 cycles late
    always @(posedge core_clk)
    begin
        pipe[0] <= {clr_set, gi_set};
        for (int i = 1; i < 16; i++)
            pipe[i] <= pipe[i - 1];
    end
    assign {deviation_zero_request, general_input} = pipe[lag];
endmodule
`default_nettype wire

// *** scc_core_tb.sv ***
// Self-checking testbench for the servo command select and clear block
`timescale 1ns/10ps
`default_nettype none
module scc_core_tb;
    logic               core_clk = 1'b0;
    logic               resetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [7:0]         general_input;
    logic               deviation_zero_request;
    logic [7:0]         gi_set = 8'h00;
    logic               clr_set = 1'b0;
    logic [3:0]         lag = 4'h0;
    logic               servo_on = 1'b0;
    logic               position_mode = 1'b0;
    logic [3:0]         stp = 4'h0;
    logic signed [15:0] mv = 16'sh0000;
    logic signed [31:0] deviation_count;
    logic               stop_on_pulse_edge;
    logic signed [16:0] speed_command_rpm;
    logic signed [16:0] feedforward_rpm;
    logic [31:0]        r;
    logic               err;
    int                 miscompares = 0;
    int                 n_checks = 0;
    int                 pre [1:3];
    int                 ffx, gain, dev, sp, ff;

    always #50 core_clk = ~core_clk;

    scc_host host (.core_clk, .gi_set, .clr_set, .lag, .general_input, .deviation_zero_request);

    scc_core dut
    (
        .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .general_input, .deviation_zero_request, .servo_on, .position_mode,
        .cmd_step_fwd(stp[3]), .cmd_step_rev(stp[2]), .fb_step_fwd(stp[1]),
        .fb_step_rev(stp[0]), .analog_cmd_mv(mv), .deviation_count, .stop_on_pulse_edge,
        .speed_command_rpm, .feedforward_rpm
    );

    task summarize;
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t register %h expected %h", $time, got, exp);
        end
    endtask

    task chk_out(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            summarize;
        end
    endtask

    // Outputs are sampled mid-cycle, away from the driving edge
    task settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task pins(input logic s, input logic c, input int n);
        @(posedge core_clk);
        servo_on <= s;
        clr_set <= c;
        settle(n);
    endtask

    task pulse(input int n, input logic [3:0] v);
        repeat (n)
        begin
            @(posedge core_clk);
            stp <= v;
            @(posedge core_clk);
            stp <= 4'h0;
        end
    endtask

    initial
    begin
        void'($urandom(94));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        position_mode <= 1'b1;
        apb(1'b0, scc_pkg::ADDR_GAIN, 32'h0000_0000);
        chk_reg(r, 32'h0000_01F4);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk_reg({r[30:0], err}, 32'h0000_0001);
        for (int s = 1; s >= 0; s--)
        begin
            apb(1'b1, scc_pkg::ADDR_CTRL, 32'(s));
            settle(2);
            chk_out({31'h0000_0000, stop_on_pulse_edge}, 32'(s));
        end
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, scc_pkg::ADDR_CTRL, 32'(m << 4));
            pins(1'b0, 1'b1, 6);
            pins(1'b1, 1'b0, 6);
            pulse(4, 4'b1000);
            pulse(1, 4'b0100);
            pulse(1, 4'b0010);
            pulse(3, 4'b0001);
            settle(1);
            chk_out(deviation_count, 32'h0000_0005);
            pins(1'b0, 1'b0, 3);
            dev = (m < 2) ? 0 : 5;
            chk_out(deviation_count, 32'(dev));
            pins(1'b1, 1'b1, 5);
            pulse(3, 4'b1000);
            dev = (m % 2 == 0) ? 0 : 3;
            settle(1);
            chk_out(deviation_count, 32'(dev));
            apb(1'b0, scc_pkg::ADDR_DEV, 32'h0000_0000);
            chk_reg(r, 32'(dev));
            pins(1'b1, 1'b0, 4);
        end
        apb(1'b1, scc_pkg::ADDR_GAIN, 32'h0000_0FFF);
        apb(1'b0, scc_pkg::ADDR_GAIN, 32'h0000_0000);
        chk_reg(r, 32'h0000_0FA0);
        apb(1'b1, scc_pkg::ADDR_FF_FIX, 32'h0000_8000);
        apb(1'b0, scc_pkg::ADDR_FF_FIX, 32'h0000_0000);
        chk_reg(r, 32'hFFFF_D8F1);
        gain = $urandom % 4001;
        ffx = int'($urandom % 19999) - 9999;
        apb(1'b1, scc_pkg::ADDR_GAIN, 32'(gain));
        apb(1'b1, scc_pkg::ADDR_FF_FIX, 32'(ffx));
        for (int i = 1; i <= 3; i++)
        begin
            pre[i] = (i == 3) ? 32767 : $urandom % 32768;
            apb(1'b1, scc_pkg::ADDR_CTRL + 8'(4 * i), 32'(pre[i]));
        end
        apb(1'b1, scc_pkg::ADDR_ASSIGN0, 32'h1514_1312);
        apb(1'b1, scc_pkg::ADDR_ASSIGN1, 32'h0019_1716);
        for (int i = 0; i < 64; i++)
        begin
            apb(1'b1, scc_pkg::ADDR_CTRL, 32'((i % 4) << 8));
            @(posedge core_clk);
            gi_set <= 8'($urandom);
            mv <= 16'(int'($urandom % 20001) - 10000);
            position_mode <= 1'($urandom);
            lag <= 4'($urandom % 4);
            settle(8);
            sp = int'(mv) * gain / 1000;
            ff = 0;
            if (position_mode && !gi_set[1])
                ff = (i % 4 == 1) ? sp : (i % 4 == 2) ? ffx : 0;
            if (gi_set[3:2] != 2'b00)
            begin
                sp = pre[gi_set[3] ? (gi_set[2] ? 3 : 2) : 1];
                if (gi_set[4])
                    sp = gi_set[5] ? -sp : sp;
                else if (gi_set[6] != gi_set[7])
                    sp = gi_set[6] ? sp : -sp;
                else
                    sp = 0;
            end
            chk_out(32'(feedforward_rpm), 32'(ff));
            if (!position_mode)
                chk_out(32'(speed_command_rpm), 32'(sp));
        end
        summarize;
    end
endmodule
`default_nettype wire
